// [verilog/abus_msg_regs.svh]
// Message codes, field positions and limits for the audio bus message handler
`ifndef ABUS_MSG_REGS_SVH
`define ABUS_MSG_REGS_SVH

// ---------------------------------------------------------------------------
// Message codes
// ---------------------------------------------------------------------------
`define MC_CONNECT_SOURCE   7'h10
`define MC_CONNECT_SINK     7'h11
`define MC_DISCONNECT_PORT  7'h14
`define MC_CHANGE_CONTENT   7'h18
`define MC_BEGIN_RECONF     7'h40
`define MC_NEXT_FRAMER      7'h44
`define MC_NEXT_SUBFRAME    7'h45
`define MC_NEXT_GEAR        7'h46
`define MC_NEXT_PAUSE       7'h4A
`define MC_NEXT_RESET_BUS   7'h4B
`define MC_NEXT_SHUTDOWN    7'h4C
`define MC_NEXT_DEF_CHAN    7'h50
`define MC_NEXT_DEF_CONTENT 7'h51
`define MC_NEXT_ACTIVATE    7'h54
`define MC_NEXT_DEACTIVATE  7'h55
`define MC_NEXT_REMOVE      7'h58
`define MC_RECONF_NOW       7'h5F
`define MC_REQUEST_VALUE    7'h60
`define MC_REPLY_VALUE      7'h64
`define MC_CHANGE_VALUE     7'h68

// ---------------------------------------------------------------------------
// Value map layout and limits
// ---------------------------------------------------------------------------
`define DEV_INTERFACE   2'h2
`define REGION_MSB      11
`define REGION_LSB      10
`define REGION_USER     2'h2
`define EC_OFS_W        10
`define RESERVED_VALUE  16'h0000
`define MIN_SLOTS       2'h2
`define NCH             8
`define CH_IDX_W        3
`define NPORT           16
`define PT_IDX_W        4
`define SL_W            5
`define CNT_TAIL_W      7

// Staged frame parameter mask bits
`define STG_LAIF   0
`define STG_SM     1
`define STG_CG     2
`define STG_PAUSE  3
`define STG_RESET  4
`define STG_SHUT   5
`define STG_W      6

`endif

// [verilog/abus_msg_pkg.sv]
// Types shared by the audio bus message handler
package abus_msg_pkg;
  `include "abus_msg_regs.svh"

  typedef struct packed {
    logic        valid;
    logic [1:0]  dev;
    logic [6:0]  code;
    logic [7:0]  tid;
    logic [11:0] ec;
    logic [15:0] a0;
    logic [15:0] a1;
    logic [15:0] a2;
  } msg_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  code;
    logic [7:0]  tid;
    logic [15:0] vs;
  } reply_t;

  typedef struct packed {
    logic                 valid;
    logic                 write;
    logic [`EC_OFS_W-1:0] addr;
    logic [15:0]          wdata;
  } reg_req_t;

  typedef struct packed {
    logic [3:0]  tp;
    logic [11:0] sd;
    logic [4:0]  sl;
  } chan_def_t;

  typedef struct packed {
    logic       fl;
    logic [6:0] pr;
    logic [3:0] af;
    logic [3:0] dt;
    logic       cl;
    logic [5:0] dl;
  } chan_cnt_t;

  typedef struct packed {
    logic       con;
    logic       src;
    logic [7:0] cn;
  } port_t;

  typedef struct packed {
    logic [7:0]  laif;
    logic [15:0] nco;
    logic [15:0] nci;
    logic [4:0]  sm;
    logic [3:0]  cg;
    logic [3:0]  rt;
    logic        pause_go;
    logic        reset_go;
    logic        shut_go;
  } frame_cfg_t;

  typedef enum logic [2:0] {RS_IDLE = 3'b001, RS_SEQ = 3'b010, RS_WAIT = 3'b100} rcfg_t;
  typedef enum logic [1:0] {SY_IDLE = 2'b01, SY_WAIT = 2'b10} sys_st_t;
endpackage

// [verilog/audio_bus_message_handler.sv]
// Message layer of the audio bus devices: value access, reconfiguration, channels
// Contract
// - Value map has core, class, user regions
// - Interface user values reach control registers
// - Other user regions read as reserved
// - Element code selects; reads carry transaction id
// - Value request answered with element contents; a request arriving while a register access is pending gets no reply
// - Reply carries id then value slice
// - Change value writes addressed element; one arriving while a register access is pending is dropped
// - Staged parameters all apply together
// - Apply at superframe two slots after
// - Begin opens, reconfigure-now closes sequence
// - Incoming framer address and idle counts
// - Stage subframe mode and clock gear
// - Pause clock with restart time
// - Reset bus clears device; shutdown announced
// - Channel takes several sinks, one source
// - Stage channel structure per channel
// - Content set by define or change
// - Activate starts channel at boundary
// - Running channel redefined without interruption
// - Deactivate pauses, activate resumes
// - Port disconnect and channel remove tear down
// - Presence bit set by pushing/pulling end; the handler carries no channel data and sets no presence bit
`timescale 1ns/1ps
`include "abus_msg_regs.svh"

module audio_bus_message_handler (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 rst_i,
  input  wire logic                                 link_clk_i,
  input  wire abus_msg_pkg::msg_t                   msg_i,
  input  wire logic                                 slot_i,
  input  wire logic                                 sframe_i,
  input  wire logic                                 reg_ack_i,
  input  wire logic [15:0]                          reg_rdata_i,
  output abus_msg_pkg::reg_req_t                    reg_req_o,
  output abus_msg_pkg::reply_t                      reply_o,
  output abus_msg_pkg::frame_cfg_t                  frame_cfg_o,
  output logic [`NCH-1:0]                           chan_act_o,
  output abus_msg_pkg::chan_def_t [`NCH-1:0]        chan_def_o,
  output abus_msg_pkg::chan_cnt_t [`NCH-1:0]        chan_cnt_o,
  output abus_msg_pkg::port_t [`NPORT-1:0]          port_tab_o
);
  import abus_msg_pkg::*;

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    rcfg_t                   rs;
    logic [1:0]              slots;
    logic [`STG_W-1:0]       stg_m;
    frame_cfg_t              stg_fr;
    chan_def_t [`NCH-1:0]    stg_def;
    logic [`NCH-1:0]         stg_def_m;
    chan_cnt_t [`NCH-1:0]    stg_cnt;
    logic [`NCH-1:0]         stg_cnt_m;
    logic [`NCH-1:0]         stg_act_m;
    logic [`NCH-1:0]         stg_deact_m;
    logic [`NCH-1:0]         stg_rem_m;
    frame_cfg_t              fr;
    chan_def_t [`NCH-1:0]    def;
    chan_cnt_t [`NCH-1:0]    cnt;
    logic [`NCH-1:0]         act;
    port_t [`NPORT-1:0]      ports;
    logic                    busy;
    logic                    rq_write;
    logic [`EC_OFS_W-1:0]    rq_addr;
    logic [15:0]             rq_wdata;
    logic [7:0]              rq_tid;
    logic                    req_tog;
    logic                    ack_s1;
    logic                    ack_s2;
    logic                    ack_s3;
    reply_t                  reply;
    logic                    applied;
  } link_state_t;

  typedef struct packed {
    sys_st_t                 st;
    logic                    req_s1;
    logic                    req_s2;
    logic                    req_s3;
    logic                    ack_tog;
    reg_req_t                req;
    logic [15:0]             rdata;
  } sys_state_t;

  link_state_t lq;
  link_state_t ld;
  sys_state_t  sq;
  sys_state_t  sd;
  logic        lrst_s1_q;
  logic        lrst_q;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic ch_ok(input logic [7:0] cn);
    return cn < 8'(`NCH);
  endfunction

  function automatic logic pt_ok(input logic [15:0] pn);
    return pn < 16'(`NPORT);
  endfunction

  // Only the interface device's user region is backed by registers
  function automatic logic user_reg(input msg_t m);
    return (m.dev == `DEV_INTERFACE) && (m.ec[`REGION_MSB:`REGION_LSB] == `REGION_USER);
  endfunction

  // -------------------------------------------------------------------------
  // Link reset synchroniser
  // -------------------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    lrst_s1_q <= rst_i;
    lrst_q    <= lrst_s1_q;
  end

  // -------------------------------------------------------------------------
  // Link domain
  // -------------------------------------------------------------------------
  always_comb begin
    msg_t m;
    logic apply;
    m = msg_i;
    apply = 1'b0;
    ld = lq;
    ld.reply.valid  = 1'b0;
    ld.applied      = 1'b0;
    ld.fr.pause_go  = 1'b0;
    ld.fr.reset_go  = 1'b0;
    ld.fr.shut_go   = 1'b0;
    ld.ack_s1 = sq.ack_tog;
    ld.ack_s2 = lq.ack_s1;
    ld.ack_s3 = lq.ack_s2;

    // Register access completed on the system side
    if (lq.busy && (lq.ack_s2 != lq.ack_s3)) begin
      ld.busy = 1'b0;
      if (!lq.rq_write) begin
        ld.reply.valid = 1'b1;
        ld.reply.code  = `MC_REPLY_VALUE;
        ld.reply.tid   = lq.rq_tid;
        ld.reply.vs    = sq.rdata;
      end
    end

    // Boundary search after the sequence is closed
    if (lq.rs == RS_WAIT) begin
      if (sframe_i && (lq.slots >= `MIN_SLOTS)) begin
        apply = 1'b1;
      end else if (slot_i && (lq.slots < `MIN_SLOTS)) begin
        ld.slots = lq.slots + 2'h1;
      end
    end

    if (m.valid) begin
      case (m.code)
        `MC_REQUEST_VALUE: begin
          if (!lq.busy) begin
            if (user_reg(m)) begin
              ld.busy     = 1'b1;
              ld.rq_write = 1'b0;
              ld.rq_addr  = m.ec[`EC_OFS_W-1:0];
              ld.rq_tid   = m.tid;
              ld.req_tog  = ~lq.req_tog;
            end else begin
              ld.reply.valid = 1'b1;
              ld.reply.code  = `MC_REPLY_VALUE;
              ld.reply.tid   = m.tid;
              ld.reply.vs    = `RESERVED_VALUE;
            end
          end
        end
        `MC_CHANGE_VALUE: begin
          if (!lq.busy && user_reg(m)) begin
            ld.busy     = 1'b1;
            ld.rq_write = 1'b1;
            ld.rq_addr  = m.ec[`EC_OFS_W-1:0];
            ld.rq_wdata = m.a0;
            ld.req_tog  = ~lq.req_tog;
          end
        end
        `MC_CONNECT_SOURCE, `MC_CONNECT_SINK: begin
          if (pt_ok(m.a1)) begin
            ld.ports[m.a1[`PT_IDX_W-1:0]].con = 1'b1;
            ld.ports[m.a1[`PT_IDX_W-1:0]].src = (m.code == `MC_CONNECT_SOURCE);
            ld.ports[m.a1[`PT_IDX_W-1:0]].cn  = m.a0[7:0];
          end
        end
        `MC_DISCONNECT_PORT: begin
          if (pt_ok(m.a1)) begin
            ld.ports[m.a1[`PT_IDX_W-1:0]] = '0;
          end
        end
        `MC_CHANGE_CONTENT: begin
          if (ch_ok(m.a0[7:0])) begin
            ld.cnt[m.a0[`CH_IDX_W-1:0]] = chan_cnt_t'({m.a1, m.a2[`CNT_TAIL_W-1:0]});
          end
        end
        `MC_BEGIN_RECONF: begin
          if (lq.rs != RS_WAIT) begin
            ld.rs = RS_SEQ;
          end
        end
        `MC_RECONF_NOW: begin
          if (lq.rs == RS_SEQ) begin
            ld.rs    = RS_WAIT;
            ld.slots = 2'h0;
          end
        end
        default: begin
          // Staging only inside an open sequence
          if (lq.rs == RS_SEQ) begin
            case (m.code)
              `MC_NEXT_FRAMER: begin
                ld.stg_fr.laif = m.a0[7:0];
                ld.stg_fr.nco  = m.a1;
                ld.stg_fr.nci  = m.a2;
                ld.stg_m[`STG_LAIF] = 1'b1;
              end
              `MC_NEXT_SUBFRAME: begin
                ld.stg_fr.sm = m.a0[4:0];
                ld.stg_m[`STG_SM] = 1'b1;
              end
              `MC_NEXT_GEAR: begin
                ld.stg_fr.cg = m.a0[3:0];
                ld.stg_m[`STG_CG] = 1'b1;
              end
              `MC_NEXT_PAUSE: begin
                ld.stg_fr.rt = m.a0[3:0];
                ld.stg_m[`STG_PAUSE] = 1'b1;
              end
              `MC_NEXT_RESET_BUS: ld.stg_m[`STG_RESET] = 1'b1;
              `MC_NEXT_SHUTDOWN:  ld.stg_m[`STG_SHUT] = 1'b1;
              `MC_NEXT_DEF_CHAN: begin
                if (ch_ok(m.a0[7:0])) begin
                  ld.stg_def[m.a0[`CH_IDX_W-1:0]]   = chan_def_t'({m.a1, m.a2[`SL_W-1:0]});
                  ld.stg_def_m[m.a0[`CH_IDX_W-1:0]] = 1'b1;
                end
              end
              `MC_NEXT_DEF_CONTENT: begin
                if (ch_ok(m.a0[7:0])) begin
                  ld.stg_cnt[m.a0[`CH_IDX_W-1:0]]   = chan_cnt_t'({m.a1, m.a2[`CNT_TAIL_W-1:0]});
                  ld.stg_cnt_m[m.a0[`CH_IDX_W-1:0]] = 1'b1;
                end
              end
              `MC_NEXT_ACTIVATE: begin
                if (ch_ok(m.a0[7:0])) begin
                  ld.stg_act_m[m.a0[`CH_IDX_W-1:0]]   = 1'b1;
                  ld.stg_deact_m[m.a0[`CH_IDX_W-1:0]] = 1'b0;
                end
              end
              `MC_NEXT_DEACTIVATE: begin
                if (ch_ok(m.a0[7:0])) begin
                  ld.stg_deact_m[m.a0[`CH_IDX_W-1:0]] = 1'b1;
                  ld.stg_act_m[m.a0[`CH_IDX_W-1:0]]   = 1'b0;
                end
              end
              `MC_NEXT_REMOVE: begin
                if (ch_ok(m.a0[7:0])) begin
                  ld.stg_rem_m[m.a0[`CH_IDX_W-1:0]] = 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
      endcase
    end

    // -------------------------------------------------------------------------
    // Boundary: every staged item lands in the same cycle
    // -------------------------------------------------------------------------
    if (apply) begin
      if (lq.stg_m[`STG_LAIF]) begin
        ld.fr.laif = lq.stg_fr.laif;
        ld.fr.nco  = lq.stg_fr.nco;
        ld.fr.nci  = lq.stg_fr.nci;
      end
      if (lq.stg_m[`STG_SM]) ld.fr.sm = lq.stg_fr.sm;
      if (lq.stg_m[`STG_CG]) ld.fr.cg = lq.stg_fr.cg;
      if (lq.stg_m[`STG_PAUSE]) ld.fr.rt = lq.stg_fr.rt;
      ld.fr.pause_go = lq.stg_m[`STG_PAUSE];
      ld.fr.reset_go = lq.stg_m[`STG_RESET];
      ld.fr.shut_go  = lq.stg_m[`STG_SHUT];
      for (int i = 0; i < `NCH; i++) begin
        // Active flag untouched here, so redefinition does not stall data
        if (lq.stg_def_m[i]) ld.def[i] = lq.stg_def[i];
        if (lq.stg_cnt_m[i]) ld.cnt[i] = lq.stg_cnt[i];
        if (lq.stg_act_m[i]) ld.act[i] = 1'b1;
        if (lq.stg_deact_m[i]) ld.act[i] = 1'b0;
        if (lq.stg_rem_m[i] || lq.stg_m[`STG_RESET]) begin
          ld.act[i] = 1'b0;
          ld.def[i] = '0;
          ld.cnt[i] = '0;
          for (int p = 0; p < `NPORT; p++) begin
            if (lq.ports[p].cn == 8'(i)) ld.ports[p] = '0;
          end
        end
      end
      // Bus reset drops every connection, as at first start-up
      if (lq.stg_m[`STG_RESET]) ld.ports = '0;
      ld.stg_m       = '0;
      ld.stg_def_m   = '0;
      ld.stg_cnt_m   = '0;
      ld.stg_act_m   = '0;
      ld.stg_deact_m = '0;
      ld.stg_rem_m   = '0;
      ld.rs          = RS_IDLE;
      ld.slots       = 2'h0;
      ld.applied     = 1'b1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_q) begin
      lq    <= '0;
      lq.rs <= RS_IDLE;
    end else begin
      lq <= ld;
    end
  end

  // -------------------------------------------------------------------------
  // System domain: register access handshake
  // -------------------------------------------------------------------------
  always_comb begin
    sd = sq;
    sd.req_s1 = lq.req_tog;
    sd.req_s2 = sq.req_s1;
    sd.req_s3 = sq.req_s2;
    case (sq.st)
      SY_IDLE: begin
        // Request fields stay still in the link domain while the toggle is in flight
        if (sq.req_s2 != sq.req_s3) begin
          sd.req.valid = 1'b1;
          sd.req.write = lq.rq_write;
          sd.req.addr  = lq.rq_addr;
          sd.req.wdata = lq.rq_wdata;
          sd.st        = SY_WAIT;
        end
      end
      SY_WAIT: begin
        if (reg_ack_i) begin
          sd.req.valid = 1'b0;
          if (!sq.req.write) sd.rdata = reg_rdata_i;
          sd.ack_tog = ~sq.ack_tog;
          sd.st      = SY_IDLE;
        end
      end
      default: sd.st = SY_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sq    <= '0;
      sq.st <= SY_IDLE;
    end else begin
      sq <= sd;
    end
  end

  assign reg_req_o   = sq.req;
  assign reply_o     = lq.reply;
  assign frame_cfg_o = lq.fr;
  assign chan_act_o  = lq.act;
  assign chan_def_o  = lq.def;
  assign chan_cnt_o  = lq.cnt;
  assign port_tab_o  = lq.ports;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_apply_boundary: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    lq.applied |-> $past(sframe_i) && ($past(lq.slots) >= `MIN_SLOTS) && ($past(lq.rs) == RS_WAIT))
    else $error("reconfiguration applied off a valid boundary");
  a_idle_no_stage: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    (lq.rs == RS_IDLE) |-> (lq.stg_m == '0) && (lq.stg_act_m == '0) && (lq.stg_def_m == '0))
    else $error("staging held outside a sequence");
  a_sm_together: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    lq.applied && $past(lq.stg_m[`STG_SM]) |-> (lq.fr.sm == $past(lq.stg_fr.sm)) && (lq.stg_m == '0))
    else $error("staged subframe mode not applied");
  a_act_applied: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    lq.applied |-> ((lq.act & $past(lq.stg_act_m & ~lq.stg_rem_m & ~{`NCH{lq.stg_m[`STG_RESET]}}))
                    == $past(lq.stg_act_m & ~lq.stg_rem_m & ~{`NCH{lq.stg_m[`STG_RESET]}})))
    else $error("scheduled channel not started");
  a_reserved_reply: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    msg_i.valid && (msg_i.code == `MC_REQUEST_VALUE) && !lq.busy && !user_reg(msg_i)
    |=> lq.reply.valid && (lq.reply.vs == `RESERVED_VALUE) && (lq.reply.tid == $past(msg_i.tid)))
    else $error("reserved read not answered next cycle");
  a_reply_tid: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    lq.busy && !lq.rq_write && (lq.ack_s2 != lq.ack_s3)
    |=> lq.reply.valid && (lq.reply.tid == $past(lq.rq_tid)) && (lq.reply.code == `MC_REPLY_VALUE))
    else $error("register reply lost or wrong id");
  a_req_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sq.req.valid && !reg_ack_i |=> sq.req.valid && $stable(sq.req.addr) && $stable(sq.req.write))
    else $error("register request dropped before acknowledge");
  a_sink_connect: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    msg_i.valid && (msg_i.code == `MC_CONNECT_SINK) && pt_ok(msg_i.a1)
    |=> lq.ports[$past(msg_i.a1[`PT_IDX_W-1:0])].con && !lq.ports[$past(msg_i.a1[`PT_IDX_W-1:0])].src)
    else $error("sink port not connected");
  a_port_teardown: assert property (@(posedge link_clk_i) disable iff (lrst_q)
    msg_i.valid && (msg_i.code == `MC_DISCONNECT_PORT) && pt_ok(msg_i.a1)
    |=> !lq.ports[$past(msg_i.a1[`PT_IDX_W-1:0])].con)
    else $error("disconnected port still connected");

  c_apply:   cover property (@(posedge link_clk_i) disable iff (lrst_q) lq.applied && (lq.act != '0));
  c_reg_rd:  cover property (@(posedge link_clk_i) disable iff (lrst_q) lq.reply.valid && lq.busy == 1'b0);
  c_reg_wr:  cover property (@(posedge sys_clk_i) disable iff (rst_i) sq.req.valid && sq.req.write && reg_ack_i);
  c_bus_rst: cover property (@(posedge link_clk_i) disable iff (lrst_q) lq.fr.reset_go);

endmodule // audio_bus_message_handler

// [tb/reg_map_model.sv]
// Register map model standing behind the handler's register request port
`timescale 1ns/1ps
module reg_map_model (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire abus_msg_pkg::reg_req_t req_i,
  input  wire logic [3:0]             lag_i,
  output logic                        ack_o,
  output logic [15:0]                 rdata_o
);
  import abus_msg_pkg::*;
  logic [15:0] mem_q [1024];
  logic [3:0]  wait_q;
  always_ff @(posedge sys_clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o; // Stale data never passes for a fresh read
    if (rst_i) begin
      wait_q  <= 4'h0;
      rdata_o <= 16'h0000;
    end else if (req_i.valid && !ack_o) begin
      if (wait_q < lag_i) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        ack_o  <= 1'b1;
        if (req_i.write) mem_q[req_i.addr] <= req_i.wdata;
        else rdata_o <= mem_q[req_i.addr];
      end
    end
  end
endmodule // reg_map_model

// [tb/audio_bus_message_handler_bench.sv]
// Self-checking bench of the audio bus message handler
`timescale 1ns/1ps
`include "abus_msg_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module audio_bus_message_handler_bench;
  import abus_msg_pkg::*;
  typedef struct packed {logic [6:0] code; logic [1:0] dev; logic [11:0] ec; logic [15:0] d; logic [15:0] e;} row_t;
  logic                        sys_clk, rst, link_clk, slot, sframe, ack;
  logic [3:0]                  lag;
  logic [15:0]                 rdata;
  msg_t                        msg;
  reg_req_t                    req;
  reply_t                      rep, last;
  frame_cfg_t                  fc;
  logic [`NCH-1:0]             act;
  chan_def_t [`NCH-1:0]        cd;
  chan_cnt_t [`NCH-1:0]        cc;
  port_t [`NPORT-1:0]          pt;
  int                          n_mismatch, n_compared, n_rep, k, n_go;
  row_t rows [7] = '{'{`MC_CHANGE_VALUE, 2'h2, 12'h812, 16'hA5C3, 16'h0000},
    '{`MC_REQUEST_VALUE, 2'h2, 12'h812, 16'h0000, 16'hA5C3}, '{`MC_REQUEST_VALUE, 2'h2, 12'h012, 16'h0000, 16'h0000},
    '{`MC_REQUEST_VALUE, 2'h2, 12'h412, 16'h0000, 16'h0000}, '{`MC_REQUEST_VALUE, 2'h1, 12'h812, 16'h0000, 16'h0000},
    '{`MC_CHANGE_VALUE, 2'h1, 12'h812, 16'h1111, 16'h0000}, '{`MC_REQUEST_VALUE, 2'h2, 12'h812, 16'h0000, 16'hA5C3}};

  audio_bus_message_handler i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .msg_i(msg),
    .slot_i(slot), .sframe_i(sframe), .reg_ack_i(ack), .reg_rdata_i(rdata), .reg_req_o(req), .reply_o(rep),
    .frame_cfg_o(fc), .chan_act_o(act), .chan_def_o(cd), .chan_cnt_o(cc), .port_tab_o(pt));
  reg_map_model i_map (.sys_clk_i(sys_clk), .rst_i(rst), .req_i(req), .lag_i(lag), .ack_o(ack), .rdata_o(rdata));

  initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
  initial begin link_clk = 1'b0; #3; forever #32 link_clk = ~link_clk; end
  always @(posedge link_clk) if (rep.valid === 1'b1) begin last <= rep; n_rep <= n_rep + 1; end
  always @(posedge link_clk) if ((fc.pause_go | fc.shut_go | fc.reset_go) === 1'b1) n_go <= n_go + 1;

  task automatic send(logic [6:0] c, logic [1:0] dv, logic [7:0] t, logic [11:0] ec, logic [15:0] a0, a1, a2);
    @(negedge link_clk);
    msg <= '{1'b1, dv, c, t, ec, a0, a1, a2};
    @(negedge link_clk);
    msg.valid <= 1'b0;
  endtask
  task automatic tick(logic s, logic f);
    @(negedge link_clk);
    slot <= s;
    sframe <= f;
    @(negedge link_clk);
    slot <= 1'b0;
    sframe <= 1'b0;
  endtask
  task automatic cmd(logic [6:0] c, logic [15:0] a0, a1);
    send(c, 2'h2, 8'h00, 12'h000, a0, a1, 16'h000A);
  endtask
  // Whole sequence closed, then two slots before the boundary
  task automatic reconf(logic [6:0] c, logic [15:0] a0);
    cmd(`MC_BEGIN_RECONF, 16'h0000, 16'h0000);
    cmd(c, a0, 16'h0000);
    cmd(`MC_RECONF_NOW, 16'h0000, 16'h0000);
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    repeat (2) @(posedge link_clk);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin #200000; n_mismatch++; tally_and_finish(); end

  initial begin
    {rst, slot, sframe, lag, msg, n_rep, n_go} = '0;
    rst = 1'b1;
    // --------------------------------------------------------------------
    // Reset: held over enough link edges for the two-stage copy
    // --------------------------------------------------------------------
    repeat (16) @(negedge link_clk);
    `CHK("act in reset", 8'h00, act)
    rst <= 1'b0;
    repeat (4) @(negedge link_clk);
    // --------------------------------------------------------------------
    // Value access rows, prompt and slow register map alternating
    // --------------------------------------------------------------------
    foreach (rows[i]) begin
      @(negedge sys_clk);
      lag = i[0] ? 4'h7 : 4'h0;
      k = n_rep;
      send(rows[i].code, rows[i].dev, 8'h30 + i[7:0], rows[i].ec, rows[i].d, 16'h0000, 16'h0000);
      repeat (40) @(posedge link_clk);
      if (rows[i].code == `MC_REQUEST_VALUE) begin
        `CHK("reply count", k + 1, n_rep)
        `CHK("reply tid", 8'h30 + i[7:0], last.tid)
        `CHK("reply code", `MC_REPLY_VALUE, last.code)
        `CHK("reply slice", rows[i].e, last.vs)
      end else `CHK("write reply", k, n_rep)
    end
    // --------------------------------------------------------------------
    // Reconfiguration: stray staging, early boundary, joint apply
    // --------------------------------------------------------------------
    cmd(`MC_NEXT_GEAR, 16'h0009, 16'h0000);
    reconf(`MC_RECONF_NOW, 16'h0000);
    `CHK("stray gear", 4'h0, fc.cg)
    cmd(`MC_BEGIN_RECONF, 16'h0000, 16'h0000);
    cmd(`MC_NEXT_SUBFRAME, 16'h0015, 16'h0000);
    cmd(`MC_NEXT_GEAR, 16'h0009, 16'h0000);
    cmd(`MC_NEXT_ACTIVATE, 16'h0001, 16'h0000);
    cmd(`MC_NEXT_DEF_CHAN, 16'h0001, 16'h3ABC);
    cmd(`MC_RECONF_NOW, 16'h0000, 16'h0000);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    `CHK("early sm", 5'h00, fc.sm)
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b1);
    repeat (2) @(posedge link_clk);
    `CHK("sm", 5'h15, fc.sm)
    `CHK("gear", 4'h9, fc.cg)
    `CHK("active", 1'b1, act[1])
    `CHK("chan def", {4'h3, 12'hABC, 5'h0A}, cd[1])
    reconf(`MC_NEXT_DEACTIVATE, 16'h0001);
    `CHK("paused", 1'b0, act[1])
    reconf(`MC_NEXT_ACTIVATE, 16'h0001);
    `CHK("resumed", 1'b1, act[1])
    reconf(`MC_NEXT_DEF_CHAN, 16'h0001);
    `CHK("redefined live", {1'b1, 16'h0000, 5'h0A}, {act[1], cd[1]})
    cmd(`MC_CHANGE_CONTENT, 16'h0002, 16'h8123);
    `CHK("content", {16'h8123, 7'h0A}, cc[2])
    reconf(`MC_NEXT_FRAMER, 16'h0005);
    `CHK("framer", {8'h05, 16'h0000, 16'h000A}, {fc.laif, fc.nco, fc.nci})
    reconf(`MC_NEXT_PAUSE, 16'h0003);
    `CHK("pause", {4'h3, 8'h01}, {fc.rt, n_go[7:0]})
    reconf(`MC_NEXT_SHUTDOWN, 16'h0000);
    `CHK("shutdown", 8'h02, n_go[7:0])
    // --------------------------------------------------------------------
    // Ports: one source, two sinks, then teardown
    // --------------------------------------------------------------------
    cmd(`MC_CONNECT_SOURCE, 16'h0001, 16'h0003);
    cmd(`MC_CONNECT_SINK, 16'h0001, 16'h0004);
    cmd(`MC_CONNECT_SINK, 16'h0001, 16'h0005);
    @(posedge link_clk);
    `CHK("src port", 10'h301, pt[3])
    `CHK("sink ports", {10'h201, 10'h201}, {pt[5], pt[4]})
    cmd(`MC_DISCONNECT_PORT, 16'h0000, 16'h0004);
    @(posedge link_clk);
    `CHK("disc port", 2'b01, {pt[4].con, pt[5].con})
    reconf(`MC_NEXT_REMOVE, 16'h0001);
    `CHK("removed", 3'b000, {pt[3].con, pt[5].con, act[1]})
    cmd(`MC_CONNECT_SOURCE, 16'h0002, 16'h0006);
    reconf(`MC_NEXT_RESET_BUS, 16'h0000);
    `CHK("bus reset", 1'b0, pt[6].con)
    `CHK("bus reset go", 8'h03, n_go[7:0])
    tally_and_finish();
  end
endmodule // audio_bus_message_handler_bench
